/* rtl/csl_pkg.sv */
// Constants for the charger status and command link.
// Assumes one 100 MHz clock and an AHB-Lite register bus.
package csl_pkg;
  // ******************************
  // Register map (byte addresses)
  // ******************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MEAS = 8'h04;
  localparam logic [7:0] ADDR_EVENTS = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_TEMP_LIMITS = 8'h10;
  localparam logic [7:0] ADDR_MAX_VOLTAGE = 8'h14;
  localparam logic [7:0] ADDR_CFG_EXTRA = 8'h18;
  // ******************************
  // Field positions and codes
  // ******************************
  localparam int EV_CFG_REQ = 0;
  localparam int EV_RESET_CMD = 1;
  localparam int EV_BAD_CMD = 2;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_RESUME = 1;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam logic [1:0] ALGO_FAST = 2'h1;
  localparam logic [1:0] ALGO_TRICKLE = 2'h2;
  localparam logic [1:0] BAT_IDLE = 2'h0;
  localparam logic [7:0] OP_SEND_CFG = 8'h3c;
  localparam logic [7:0] OP_RESET = 8'h55;
  localparam int CFG_BYTES = 8;
  localparam logic [3:0] REPLY_LAST = 4'h8;
  localparam logic [31:0] CFG_EXTRA_RST = 32'h0000_0000;
  localparam logic [15:0] TEMP_LIMITS_RST = 16'h0000;
  localparam logic [15:0] MAX_VOLTAGE_RST = 16'h0000;
  localparam int AVG_SHIFT = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int BYTE_W = 8;
  // Command parser states
  typedef enum logic [1:0] {CSL_IDLE, CSL_SECOND, CSL_REPLY} csl_state_t;
endpackage : csl_pkg

/* rtl/csl_stream_if.sv */
// Valid/ready byte stream between the command logic and the reply FIFO.
// Assumes both ends on one clock.
`timescale 1ns/1ps
interface csl_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : csl_stream_if

/* rtl/csl_fifo.sv */
// Synchronous FIFO, valid/ready on both sides.
// Assumes a synchronous active-high reset already released cleanly.
`timescale 1ns/1ps
module csl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  csl_stream_if.snk wr,
  csl_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("csl_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Honest full and empty straight from the count
  assign wr.ready = (count_reg != DEPTH[AW:0]);
  assign rd.valid = (count_reg != '0);
  assign rd.data = mem[rd_ptr_reg];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : csl_fifo

/* rtl/csl_link.sv */
// Charger status encoder and host command interpreter.
// Assumes host bytes arrive from a UART on CLK, replies leave via TX stream.
//
// Contract
// - status bits 7-6 give charge algorithm
// - status bits 3-2 give battery 2 state
// - status bits 1-0 give battery 1 state
// - battery 1 error byte, eight flags
// - battery 2 error byte, same layout
// - battery 1 signed running-average voltage change
// - battery 2 signed running-average voltage change
// - battery 1 unsigned running-average temperature rate
// - battery 2 unsigned running-average temperature rate
// - 3Ch C3h requests the configuration set
// - reply: temp limits, max voltage, rest, checksum
// - 55h AAh soft-resets the battery controller
// - reset command halts all charge and discharge
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module csl_link #(
  parameter int FIFO_DEPTH = csl_pkg::FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic [1:0] CHARGE_ALGO,
  input wire logic [1:0] TERM_ALGO,
  input wire logic [1:0] BAT1_STATE,
  input wire logic [1:0] BAT2_STATE,
  input wire logic [7:0] BAT1_ERR,
  input wire logic [7:0] BAT2_ERR,
  input wire logic SAMPLE_STB,
  input wire logic [7:0] BAT1_VOLT,
  input wire logic [7:0] BAT2_VOLT,
  input wire logic [7:0] BAT1_TRATE,
  input wire logic [7:0] BAT2_TRATE,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  output logic RX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  output logic CTRL_RESET,
  output logic HALT_CHARGE
);
  // ******************************
  // Reset release
  // ******************************
  logic [1:0] rst_sync_reg;
  logic rst;

  // Release through two flops so every flop leaves reset on one edge
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst = !rst_sync_reg[1];

  // ******************************
  // Helpers
  // ******************************
  // Moves average a quarter of the way towards the new value
  function automatic logic [7:0] run_avg(input logic signed [9:0] avg, input logic signed [9:0] smp);
    logic signed [9:0] step;
    logic signed [9:0] sum;
    step = (smp - avg) >>> csl_pkg::AVG_SHIFT;
    sum = avg + step;
    return sum[7:0];
  endfunction : run_avg

  // Saturates a sample difference to the signed byte range
  function automatic logic signed [9:0] clamp8(input logic signed [9:0] d);
    if (d > 10'sd127) begin
      return 10'sd127;
    end else if (d < -10'sd128) begin
      return -10'sd128;
    end
    return d;
  endfunction : clamp8

  // ******************************
  // Status and measurement bytes
  // ******************************
  logic [7:0] volt_in [2];
  logic [7:0] trate_in [2];
  logic [7:0] volt_prev_reg [2];
  logic [7:0] dv_avg_reg [2];
  logic [7:0] dtr_avg_reg [2];
  logic have_prev_reg;
  logic halt_reg;
  logic [7:0] charge_status;

  assign volt_in[0] = BAT1_VOLT;
  assign volt_in[1] = BAT2_VOLT;
  assign trate_in[0] = BAT1_TRATE;
  assign trate_in[1] = BAT2_TRATE;

  // While halted both batteries read as idle
  assign charge_status = {CHARGE_ALGO, TERM_ALGO,
                          halt_reg ? csl_pkg::BAT_IDLE : BAT2_STATE,
                          halt_reg ? csl_pkg::BAT_IDLE : BAT1_STATE};

  // Running averages, first sample seeds the previous voltage and feeds only the rate averages
  always_ff @(posedge CLK) begin
    if (rst) begin
      have_prev_reg <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        volt_prev_reg[i] <= 8'h00;
        dv_avg_reg[i] <= 8'h00;
        dtr_avg_reg[i] <= 8'h00;
      end
    end else if (SAMPLE_STB) begin
      have_prev_reg <= 1'b1;
      for (int i = 0; i < 2; i++) begin
        volt_prev_reg[i] <= volt_in[i];
        if (have_prev_reg) begin
          dv_avg_reg[i] <= run_avg($signed({{2{dv_avg_reg[i][7]}}, dv_avg_reg[i]}),
                                   clamp8($signed({2'h0, volt_in[i]}) - $signed({2'h0, volt_prev_reg[i]})));
        end
        dtr_avg_reg[i] <= run_avg($signed({2'h0, dtr_avg_reg[i]}), $signed({2'h0, trate_in[i]}));
      end
    end
  end

  // ******************************
  // Register file
  // ******************************
  logic enable_reg;
  logic [2:0] events_reg;
  logic [7:0] temp_limit_low;
  logic [7:0] temp_limit_high;
  logic [15:0] max_voltage_reg;
  logic [31:0] cfg_extra_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic addr_phase;
  logic [31:0] rd_next;
  logic [2:0] ev_set;
  logic resume_wr;
  logic [2:0] ev_clr;

  assign addr_phase = HSEL && HREADY && HTRANS[1];
  assign resume_wr = wr_pend_reg && wr_addr_reg == csl_pkg::ADDR_CTRL && HWDATA[csl_pkg::CTRL_RESUME];
  assign ev_clr = (wr_pend_reg && wr_addr_reg == csl_pkg::ADDR_EVENTS) ? HWDATA[2:0] : 3'h0;

  // Read mux, unmapped words read as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (HADDR[7:0])
      csl_pkg::ADDR_STATUS: rd_next = {8'h00, BAT2_ERR, BAT1_ERR, charge_status};
      csl_pkg::ADDR_MEAS: rd_next = {dtr_avg_reg[1], dv_avg_reg[1], dtr_avg_reg[0], dv_avg_reg[0]};
      csl_pkg::ADDR_EVENTS: rd_next = {29'h0, events_reg};
      csl_pkg::ADDR_CTRL: rd_next = {30'h0, halt_reg, enable_reg};
      csl_pkg::ADDR_TEMP_LIMITS: rd_next = {16'h0000, temp_limit_high, temp_limit_low};
      csl_pkg::ADDR_MAX_VOLTAGE: rd_next = {16'h0000, max_voltage_reg};
      csl_pkg::ADDR_CFG_EXTRA: rd_next = cfg_extra_reg;
      default: rd_next = 32'h0000_0000;
    endcase
    if (HADDR[31:8] != 24'h0) begin
      rd_next = 32'h0000_0000;
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge CLK) begin
    if (rst) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend_reg <= addr_phase && HWRITE && HADDR[31:8] == 24'h0;
      if (addr_phase) begin
        wr_addr_reg <= HADDR[7:0];
      end
      if (addr_phase && !HWRITE) begin
        HRDATA <= rd_next;
      end
    end
  end

  // Writable configuration and control
  always_ff @(posedge CLK) begin
    if (rst) begin
      enable_reg <= csl_pkg::CTRL_ENABLE_RST;
      {temp_limit_high, temp_limit_low} <= csl_pkg::TEMP_LIMITS_RST;
      max_voltage_reg <= csl_pkg::MAX_VOLTAGE_RST;
      cfg_extra_reg <= csl_pkg::CFG_EXTRA_RST;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        csl_pkg::ADDR_CTRL: enable_reg <= HWDATA[csl_pkg::CTRL_ENABLE];
        csl_pkg::ADDR_TEMP_LIMITS: {temp_limit_high, temp_limit_low} <= HWDATA[15:0];
        csl_pkg::ADDR_MAX_VOLTAGE: max_voltage_reg <= HWDATA[15:0];
        csl_pkg::ADDR_CFG_EXTRA: cfg_extra_reg <= HWDATA;
        default: ;
      endcase
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge CLK) begin
    if (rst) begin
      events_reg <= 3'h0;
    end else begin
      events_reg <= (events_reg & ~ev_clr) | ev_set;
    end
  end

  // ******************************
  // Command interpreter
  // ******************************
  csl_pkg::csl_state_t state_reg;
  logic [7:0] op_reg;
  logic [3:0] idx_reg;
  logic [7:0] sum_reg;
  logic [7:0] reply_byte;
  logic rx_take;
  logic pair_ok;
  logic tx_load;
  csl_stream_if #(.WIDTH(csl_pkg::BYTE_W)) push_if ();
  csl_stream_if #(.WIDTH(csl_pkg::BYTE_W)) pop_if ();

  assign rx_take = RX_VALID && RX_READY;
  assign pair_ok = (RX_DATA == ~op_reg);

  // Reply order: limits, max voltage, extra fields, checksum
  always_comb begin
    unique case (idx_reg)
      4'h0: reply_byte = temp_limit_low;
      4'h1: reply_byte = temp_limit_high;
      4'h2: reply_byte = max_voltage_reg[7:0];
      4'h3: reply_byte = max_voltage_reg[15:8];
      4'h4: reply_byte = cfg_extra_reg[7:0];
      4'h5: reply_byte = cfg_extra_reg[15:8];
      4'h6: reply_byte = cfg_extra_reg[23:16];
      4'h7: reply_byte = cfg_extra_reg[31:24];
      default: reply_byte = sum_reg;
    endcase
  end

  assign push_if.valid = (state_reg == csl_pkg::CSL_REPLY);
  assign push_if.data = reply_byte;

  // Command events for the sticky register
  always_comb begin
    ev_set = 3'h0;
    if (rx_take && state_reg == csl_pkg::CSL_SECOND) begin
      ev_set[csl_pkg::EV_CFG_REQ] = pair_ok && op_reg == csl_pkg::OP_SEND_CFG;
      ev_set[csl_pkg::EV_RESET_CMD] = pair_ok && op_reg == csl_pkg::OP_RESET;
      ev_set[csl_pkg::EV_BAD_CMD] = !pair_ok;
    end else if (rx_take) begin
      ev_set[csl_pkg::EV_BAD_CMD] = RX_DATA != csl_pkg::OP_SEND_CFG && RX_DATA != csl_pkg::OP_RESET;
    end
  end

  // Two-byte parser; no new bytes taken while a reply is being written into the FIFO
  always_ff @(posedge CLK) begin
    if (rst) begin
      state_reg <= csl_pkg::CSL_IDLE;
      op_reg <= 8'h00;
      idx_reg <= 4'h0;
      sum_reg <= 8'h00;
      RX_READY <= 1'b0;
    end else begin
      RX_READY <= enable_reg && state_reg != csl_pkg::CSL_REPLY && !(rx_take && state_reg == csl_pkg::CSL_SECOND);
      unique case (state_reg)
        csl_pkg::CSL_IDLE: if (rx_take && (RX_DATA == csl_pkg::OP_SEND_CFG || RX_DATA == csl_pkg::OP_RESET)) begin
          op_reg <= RX_DATA;
          state_reg <= csl_pkg::CSL_SECOND;
        end
        csl_pkg::CSL_SECOND: if (rx_take) begin
          idx_reg <= 4'h0;
          sum_reg <= 8'h00;
          state_reg <= (pair_ok && op_reg == csl_pkg::OP_SEND_CFG) ? csl_pkg::CSL_REPLY : csl_pkg::CSL_IDLE;
        end
        csl_pkg::CSL_REPLY: if (push_if.ready) begin
          sum_reg <= sum_reg + reply_byte;
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == csl_pkg::REPLY_LAST) begin
            state_reg <= csl_pkg::CSL_IDLE;
          end
        end
      endcase
      if (!enable_reg) begin
        RX_READY <= 1'b0;
      end
    end
  end

  // Reset command: one-cycle controller reset, halt held until resumed
  always_ff @(posedge CLK) begin
    if (rst) begin
      CTRL_RESET <= 1'b0;
      halt_reg <= 1'b0;
    end else begin
      CTRL_RESET <= ev_set[csl_pkg::EV_RESET_CMD];
      if (ev_set[csl_pkg::EV_RESET_CMD]) begin
        halt_reg <= 1'b1;
      end else if (resume_wr) begin
        halt_reg <= 1'b0;
      end
    end
  end
  assign HALT_CHARGE = halt_reg;

  // ******************************
  // Reply FIFO and output stage
  // ******************************
  csl_fifo #(.WIDTH(csl_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst(rst),
    .wr(push_if),
    .rd(pop_if)
  );

  // Register the head so TX outputs come from flops; a stalled TX fills the FIFO
  assign tx_load = !TX_VALID || TX_READY;
  assign pop_if.ready = tx_load;

  always_ff @(posedge CLK) begin
    if (rst) begin
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
    end else if (tx_load) begin
      TX_VALID <= pop_if.valid;
      TX_DATA <= pop_if.data;
    end
  end
endmodule : csl_link

/* testbench/csl_link_assertions.sv */
// Checker for the status and command link; sees the top ports only.
// Assumes the bind below; every check is on CLK and off while RESETN is low.
`timescale 1ns/1ps
module csl_link_assertions #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic HREADY,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_READY,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_READY,
  input wire logic CTRL_RESET,
  input wire logic HALT_CHARGE
);
  // ****
  // Checks
  // ****
  // A byte taken this cycle; a pair only counts on consecutive takes
  logic took;
  assign took = RX_VALID && RX_READY;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_cfg_reply: assert property (took && RX_DATA == 8'h3c ##1 took && RX_DATA == 8'hc3 |-> ##[1:8] TX_VALID)
    else $error("no reply after a config request");
  a_pair_gap: assert property (took && (RX_DATA == 8'h3c || RX_DATA == 8'h55) ##1 took |=> !RX_READY)
    else $error("input not paused after a command pair");
  a_reply_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("reply byte changed while stalled");
  a_reset_pulse: assert property (took && RX_DATA == 8'h55 ##1 took && RX_DATA == 8'haa |-> ##[1:3] CTRL_RESET)
    else $error("no soft reset after reset command");
  a_reset_single: assert property (CTRL_RESET |=> !CTRL_RESET)
    else $error("soft reset pulse too long");
  a_halt_follows: assert property (CTRL_RESET |=> HALT_CHARGE)
    else $error("halt missing after soft reset");
  a_halt_cause: assert property ($rose(HALT_CHARGE) |-> CTRL_RESET || $past(CTRL_RESET))
    else $error("halt raised without reset command");
  // Only a bus write can lift the halt, and it lands two edges on
  a_halt_holds: assert property (HALT_CHARGE && !$past(HSEL && HREADY && HTRANS[1] && HWRITE) |=> HALT_CHARGE)
    else $error("halt dropped without a bus write");
  a_bad_pair: assert property (took && RX_DATA == 8'h55 ##1 took && RX_DATA != 8'haa |=> !CTRL_RESET [*3])
    else $error("soft reset on a bad pair");
endmodule : csl_link_assertions

bind csl_link csl_link_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.CLK(CLK), .RESETN(RESETN), .HSEL(HSEL),
  .HREADY(HREADY), .HTRANS(HTRANS), .HWRITE(HWRITE), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_READY(RX_READY),
  .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .CTRL_RESET(CTRL_RESET), .HALT_CHARGE(HALT_CHARGE));

/* testbench/csl_host_model.sv */
// Host side model: sends command pairs, takes reply bytes with stalls.
// Assumes one caller at a time drives send_pair.
`timescale 1ns/1ps
module csl_host_model (
  input wire logic CLK,
  output logic RX_VALID,
  output logic [7:0] RX_DATA,
  input wire logic RX_READY,
  output logic TX_READY
);
  // Quiet line at start
  initial begin
    RX_VALID = 1'b0;
    RX_DATA = 8'h00;
    TX_READY = 1'b0;
  end
  // Stall about one cycle in four so the reply has to wait
  always @(posedge CLK) TX_READY <= ($urandom % 4) != 0;
  // Opcode then second byte back to back; released line shows no stale byte
  task automatic send_pair(input logic [7:0] a, input logic [7:0] b);
    RX_VALID <= 1'b1;
    RX_DATA <= a;
    do @(posedge CLK); while (RX_READY !== 1'b1);
    RX_DATA <= b;
    do @(posedge CLK); while (RX_READY !== 1'b1);
    RX_VALID <= 1'b0;
    RX_DATA <= ~b;
  endtask : send_pair
endmodule : csl_host_model

/* testbench/csl_link_test.sv */
// Self-checking bench for the status and command link.
// Assumes the host model on the byte streams and a lone AHB-Lite slave.
`timescale 1ns/1ps
module csl_link_test;
  logic CLK = 1'b0, RESETN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, SAMPLE_STB = 1'b0;
  logic [1:0] HTRANS = 2'h0, CHARGE_ALGO = 2'h0, TERM_ALGO = 2'h0, BAT1_STATE = 2'h0, BAT2_STATE = 2'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, t, m, x;
  logic [7:0] BAT1_ERR = 8'h00, BAT2_ERR = 8'h00, BAT1_VOLT = 8'h00, BAT2_VOLT = 8'h00;
  logic [7:0] BAT1_TRATE = 8'h00, BAT2_TRATE = 8'h00, sum;
  wire logic HREADYOUT, HRESP, RX_VALID, RX_READY, TX_VALID, TX_READY, CTRL_RESET, HALT_CHARGE;
  wire logic [31:0] HRDATA;
  wire logic [7:0] RX_DATA, TX_DATA;
  logic [31:0] rq[$], tq[$];
  logic [7:0] cb[8];
  int n_errors = 0, checks = 0, av1 = 0, av2 = 0, at1 = 0, at2 = 0, pv1 = 0, pv2 = 0;
  logic rd_ph = 1'b0;
  csl_link u_dut (.CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
    .CHARGE_ALGO(CHARGE_ALGO), .TERM_ALGO(TERM_ALGO), .BAT1_STATE(BAT1_STATE), .BAT2_STATE(BAT2_STATE),
    .BAT1_ERR(BAT1_ERR), .BAT2_ERR(BAT2_ERR), .SAMPLE_STB(SAMPLE_STB), .BAT1_VOLT(BAT1_VOLT), .BAT2_VOLT(BAT2_VOLT),
    .BAT1_TRATE(BAT1_TRATE), .BAT2_TRATE(BAT2_TRATE), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_READY(RX_READY),
    .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .CTRL_RESET(CTRL_RESET), .HALT_CHARGE(HALT_CHARGE));
  csl_host_model u_host (.CLK(CLK), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_READY(RX_READY), .TX_READY(TX_READY));
  // ****
  // Clock, checks and verdict
  // ****
  always #5 CLK = ~CLK;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // Results are matched to the oldest note; an empty queue yields x and fails
  always @(posedge CLK) begin
    if (rd_ph && HREADYOUT === 1'b1) check("read data", HRDATA, rq.size() ? rq.pop_front() : 32'hx);
    if (rd_ph && HREADYOUT === 1'b1) check("response", HRESP, 32'h0);
    if (TX_VALID === 1'b1 && TX_READY === 1'b1) check("reply", {24'h0, TX_DATA}, tq.size() ? tq.pop_front() : 32'hx);
    if (HREADYOUT === 1'b1) rd_ph = HSEL && HTRANS[1] && !HWRITE;
  end
  // One single transfer; the master waits as long as the slave asks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    if (w) HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Sample strobe plus running-average model; the seed sample sets previous voltage and feeds only the rate averages
  task automatic samp(input bit seed, input logic [7:0] v1, input logic [7:0] v2, input logic [7:0] t1,
    input logic [7:0] t2);
    int d1, d2;
    d1 = int'(v1) - pv1;
    d2 = int'(v2) - pv2;
    d1 = d1 > 127 ? 127 : (d1 < -128 ? -128 : d1);
    d2 = d2 > 127 ? 127 : (d2 < -128 ? -128 : d2);
    if (!seed) begin
      av1 = av1 + ((d1 - av1) >>> 2);
      av2 = av2 + ((d2 - av2) >>> 2);
    end
    // Rate averages need no previous value, so they take the seed sample too
    at1 = at1 + ((int'(t1) - at1) >>> 2);
    at2 = at2 + ((int'(t2) - at2) >>> 2);
    pv1 = v1;
    pv2 = v2;
    {BAT1_VOLT, BAT2_VOLT, BAT1_TRATE, BAT2_TRATE, SAMPLE_STB} <= {v1, v2, t1, t2, 1'b1};
    @(posedge CLK);
    SAMPLE_STB <= 1'b0;
    @(posedge CLK);
  endtask : samp
  task automatic wait_reply;
    for (int k = 0; k < 300 && tq.size() != 0; k++) @(posedge CLK);
    check("reply count", tq.size(), 32'h0);
  endtask : wait_reply
  // Hang guard, well beyond the couple of hundred cycles of the run
  initial begin
    #300us;
    n_errors++;
    tally_and_finish();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    void'($urandom(13));
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (4) @(posedge CLK);
    // Every state code, a walking error flag, random term and flags
    for (int i = 0; i < 8; i++) begin
      {CHARGE_ALGO, TERM_ALGO, BAT1_STATE, BAT2_STATE} <= {i[1:0], 2'($urandom), i[1:0], i[2:1]};
      {BAT1_ERR, BAT2_ERR} <= {8'($urandom), 8'h01 << i};
      @(posedge CLK);
      rd(csl_pkg::ADDR_STATUS, {8'h0, BAT2_ERR, BAT1_ERR, CHARGE_ALGO, TERM_ALGO, BAT2_STATE, BAT1_STATE});
    end
    // Averages: full-range steps hit the clamp
    samp(1'b1, 8'h10, 8'hf0, 8'h40, 8'h80);
    for (int i = 0; i < 6; i++) samp(1'b0, 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
    rd(csl_pkg::ADDR_MEAS, {at2[7:0], av2[7:0], at1[7:0], av1[7:0]});
    // Configuration set and its reply
    {t, m, x} = {$urandom, $urandom, $urandom};
    bus(1'b1, csl_pkg::ADDR_TEMP_LIMITS, {16'h0, t[15:0]});
    bus(1'b1, csl_pkg::ADDR_MAX_VOLTAGE, {16'h0, m[15:0]});
    bus(1'b1, csl_pkg::ADDR_CFG_EXTRA, x);
    rd(csl_pkg::ADDR_TEMP_LIMITS, {16'h0, t[15:0]});
    cb = '{t[7:0], t[15:8], m[7:0], m[15:8], x[7:0], x[15:8], x[23:16], x[31:24]};
    sum = 8'h00;
    foreach (cb[i]) begin
      tq.push_back({24'h0, cb[i]});
      sum = sum + cb[i];
    end
    tq.push_back({24'h0, sum});
    u_host.send_pair(8'h3c, 8'hc3);
    wait_reply();
    rd(csl_pkg::ADDR_EVENTS, 32'h1);
    // Pairs failing the complement test, and a pair with an unknown opcode
    u_host.send_pair(8'h3c, 8'h3d);
    u_host.send_pair(8'h55, 8'hab);
    u_host.send_pair(8'h11, 8'hee);
    repeat (12) @(posedge CLK);
    check("halt", HALT_CHARGE, 32'h0);
    rd(csl_pkg::ADDR_EVENTS, 32'h5);
    bus(1'b1, csl_pkg::ADDR_EVENTS, 32'h5);
    rd(csl_pkg::ADDR_EVENTS, 32'h0);
    // Reset command halts both batteries until resumed
    u_host.send_pair(8'h55, 8'haa);
    repeat (3) @(posedge CLK);
    check("halt", HALT_CHARGE, 32'h1);
    rd(csl_pkg::ADDR_STATUS, {8'h0, BAT2_ERR, BAT1_ERR, CHARGE_ALGO, TERM_ALGO, 4'h0});
    rd(csl_pkg::ADDR_EVENTS, 32'h2);
    rd(csl_pkg::ADDR_CTRL, 32'h3);
    bus(1'b1, csl_pkg::ADDR_CTRL, 32'h3);
    rd(csl_pkg::ADDR_CTRL, 32'h1);
    // Disabled input, unmapped place
    bus(1'b1, csl_pkg::ADDR_CTRL, 32'h0);
    repeat (2) @(posedge CLK);
    check("rx ready", RX_READY, 32'h0);
    bus(1'b1, csl_pkg::ADDR_CTRL, 32'h1);
    bus(1'b1, 8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0);
    repeat (4) @(posedge CLK);
    check("reads left", rq.size(), 32'h0);
    tally_and_finish();
  end
endmodule : csl_link_test
